// *** sei_pkg.sv ***
package sei_pkg;

	// opcode and word address; the start bit is not counted
	localparam int OPCODE_W    = 2;
	localparam int ADDR_FIELD_W = 6;
	localparam int CMD_W       = OPCODE_W + ADDR_FIELD_W;
	localparam int WORD_W      = 16;
	localparam int WORDS_DFLT  = 64;

	// positions inside the 8-bit command word
	localparam int OPCODE_MSB  = 7;
	localparam int OPCODE_LSB  = 6;
	localparam int SUBOP_MSB   = 5;
	localparam int SUBOP_LSB   = 4;

	// bit counts of each phase, as last index of a 0-based count
	localparam logic [4:0] CMD_LAST_BIT  = 5'h07;
	localparam logic [4:0] DATA_LAST_BIT = 5'h0F;
	localparam logic [4:0] READ_LAST_BIT = 5'h10;

	// opcode and sub-opcode encodings
	localparam logic [1:0] OPC_SPECIAL = 2'h0;
	localparam logic [1:0] OPC_WRITE   = 2'h1;
	localparam logic [1:0] OPC_READ    = 2'h2;
	localparam logic [1:0] OPC_ERASE   = 2'h3;
	localparam logic [1:0] SUB_DISABLE = 2'h0;
	localparam logic [1:0] SUB_WR_ALL  = 2'h1;
	localparam logic [1:0] SUB_ER_ALL  = 2'h2;
	localparam logic [1:0] SUB_ENABLE  = 2'h3;

	localparam logic [15:0] ERASED_WORD = 16'hFFFF;

	// self-timed programming cycle
	localparam int CLK_PERIOD_NS = 100;
	localparam int T_PROG_NS     = 10_000_000;
	localparam int PROG_CYCLES   = T_PROG_NS / CLK_PERIOD_NS;

	// reset values
	localparam logic RST_ENABLE = 1'b0;
	localparam logic RST_BUSY   = 1'b0;

	typedef enum logic [2:0] {
		SEI_OP_NONE    = 3'h0,
		SEI_OP_READ    = 3'h1,
		SEI_OP_WRITE   = 3'h2,
		SEI_OP_ERASE   = 3'h3,
		SEI_OP_WR_ALL  = 3'h4,
		SEI_OP_ER_ALL  = 3'h5,
		SEI_OP_ENABLE  = 3'h6,
		SEI_OP_DISABLE = 3'h7
	} sei_op_t;

	typedef enum logic [4:0] {
		SEI_LK_IDLE = 5'h01,
		SEI_LK_CMD  = 5'h02,
		SEI_LK_DATA = 5'h04,
		SEI_LK_READ = 5'h08,
		SEI_LK_DONE = 5'h10
	} sei_link_state_t;

endpackage

// *** sei_sync2.sv ***
module sei_sync2 #(
	parameter int W = 1
) (
	input  wire logic         i_clk,
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);
	logic [W-1:0] meta_q;

	// first stage feeds only the second stage
	always_ff @(posedge i_clk) begin
		meta_q <= i_async;
		o_sync <= meta_q;
	end

endmodule

// *** sei_engine.sv ***
// Function
// - a first 1 seen while selected and idle starts an instruction
// - eight bits follow: two opcode bits, then six address bits
// - read copies the addressed word into a 16-bit shift register, shifted out
// - a single 0 dummy bit precedes the read data
// - read output changes only on a rising serial clock edge
// - programming is disabled after reset until enabled
// - enable persists until program_disable or power loss
// - erase sets all bits of the addressed word to 1
// - erase cycle starts on chip select falling after last address bit
// - with select high again, output shows 0 busy, 1 ready
// - write takes 16 data bits and stores them in the addressed word
// - erase_all sets every word to all ones, sequenced like erase
// - write_all stores the shifted pattern in every word, like write
// - program_disable blocks every erase and write
// - reads run whether programming is enabled or not
// - writes need no prior erase
// - opcode 10 read, 01 write, 11 erase, each with an address
// - opcode 00 uses top address bits: 11 en, 10 erase_all, 01 write_all, 00 dis
// - 16-bit words, 16 or 64 of them; low address bits select a word
module sei_engine
	import sei_pkg::*;
#(
	parameter int WORDS       = sei_pkg::WORDS_DFLT,
	parameter int PROG_CYCLES = sei_pkg::PROG_CYCLES
) (
	input  wire logic i_clk_sys,
	input  wire logic i_reset_n,
	input  wire logic i_serial_clock_pin,
	input  wire logic i_chip_select,
	input  wire logic i_serial_in,
	output logic      o_data_out,
	output logic      o_data_oe,
	output logic      o_status_out,
	output logic      o_status_oe,
	output logic      o_busy
);
	import sei_pkg::*;

	// word index width; only the low address bits reach the array
	localparam int AW     = $clog2(WORDS);
	localparam int PROG_W = $clog2(PROG_CYCLES + 1);

	// decode of the full command word, read on the last command bit;
	// opcode 00 falls through to the sub-operation field
	function automatic sei_op_t sei_decode(input logic [CMD_W-1:0] cmd);
		sei_op_t op;
		op = SEI_OP_NONE;
		case (cmd[OPCODE_MSB:OPCODE_LSB])
			OPC_READ:  op = SEI_OP_READ;
			OPC_WRITE: op = SEI_OP_WRITE;
			OPC_ERASE: op = SEI_OP_ERASE;
			default: begin
				case (cmd[SUBOP_MSB:SUBOP_LSB])
					SUB_ENABLE: op = SEI_OP_ENABLE;
					SUB_ER_ALL: op = SEI_OP_ER_ALL;
					SUB_WR_ALL: op = SEI_OP_WR_ALL;
					default:    op = SEI_OP_DISABLE;
				endcase
			end
		endcase
		return op;
	endfunction

	// nonvolatile array, no reset on purpose
	logic [WORD_W-1:0] mem_q [WORDS];

	// ---------------- link domain ----------------
	sei_link_state_t   lk_state_q;
	logic [CMD_W-2:0]  cmd_q;
	logic [CMD_W-1:0]  cmd_word;
	logic [4:0]        bit_cnt_q;
	logic [WORD_W-1:0] shift_q;
	logic [WORD_W-1:0] data_in_word;
	sei_op_t           cmd_op;
	logic              link_rst_n;
	logic              enable_q;
	logic              armed_q;
	logic              req_tgl_q;
	logic              sb_tgl_q;
	sei_op_t           pend_op_q;
	logic [AW-1:0]     pend_addr_q;
	logic [WORD_W-1:0] pend_data_q;

	// command word takes the bit now on the pin, so decode needs no extra edge
	assign cmd_word     = {cmd_q, i_serial_in};
	assign cmd_op       = sei_decode(cmd_word);
	assign data_in_word = {shift_q[WORD_W-2:0], i_serial_in};

	// link reset only takes effect while the serial clock toggles
	sei_sync2 #(.W(1)) u_link_rst (
		.i_clk   (i_serial_clock_pin),
		.i_async (i_reset_n),
		.o_sync  (link_rst_n)
	);

	// deselect clears the sequencer and floats the data driver at once,
	// since the serial clock need not run while select is low
	always_ff @(posedge i_serial_clock_pin or negedge i_chip_select) begin
		if (!i_chip_select) begin
			lk_state_q <= SEI_LK_IDLE;
			bit_cnt_q  <= 5'h00;
			cmd_q      <= '0;
			shift_q    <= '0;
			o_data_out <= 1'b0;
			o_data_oe  <= 1'b0;
		end else if (!link_rst_n) begin
			lk_state_q <= SEI_LK_IDLE;
			bit_cnt_q  <= 5'h00;
			cmd_q      <= '0;
			shift_q    <= '0;
			o_data_out <= 1'b0;
			o_data_oe  <= 1'b0;
		end else begin
			case (lk_state_q)
				SEI_LK_IDLE: begin
					if (i_serial_in) begin
						lk_state_q <= SEI_LK_CMD;
						bit_cnt_q  <= 5'h00;
					end
				end
				SEI_LK_CMD: begin
					cmd_q     <= cmd_word[CMD_W-2:0];
					bit_cnt_q <= bit_cnt_q + 5'h01;
					if (bit_cnt_q == CMD_LAST_BIT) begin
						bit_cnt_q <= 5'h00;
						if (cmd_op == SEI_OP_READ) begin
							// array is static here: host reads only when ready
							shift_q    <= mem_q[cmd_word[AW-1:0]];
							o_data_out <= 1'b0;
							o_data_oe  <= 1'b1;
							lk_state_q <= SEI_LK_READ;
						end else if (cmd_op == SEI_OP_WRITE || cmd_op == SEI_OP_WR_ALL) begin
							lk_state_q <= SEI_LK_DATA;
						end else begin
							lk_state_q <= SEI_LK_DONE;
						end
					end
				end
				SEI_LK_DATA: begin
					shift_q   <= data_in_word;
					bit_cnt_q <= bit_cnt_q + 5'h01;
					if (bit_cnt_q == DATA_LAST_BIT) begin
						lk_state_q <= SEI_LK_DONE;
					end
				end
				SEI_LK_READ: begin
					bit_cnt_q <= bit_cnt_q + 5'h01;
					if (bit_cnt_q == READ_LAST_BIT) begin
						o_data_oe  <= 1'b0;
						o_data_out <= 1'b0;
						lk_state_q <= SEI_LK_DONE;
					end else begin
						o_data_out <= shift_q[WORD_W-1];
						shift_q    <= {shift_q[WORD_W-2:0], 1'b0};
					end
				end
				SEI_LK_DONE: begin
					// wait here for deselect; further bits are ignored
					lk_state_q <= SEI_LK_DONE;
				end
				default: begin
					lk_state_q <= SEI_LK_IDLE;
				end
			endcase
		end
	end

	// enable latch and hand-off words survive deselect
	always_ff @(posedge i_serial_clock_pin) begin
		if (!link_rst_n) begin
			enable_q    <= RST_ENABLE;
			armed_q     <= 1'b0;
			req_tgl_q   <= 1'b0;
			sb_tgl_q    <= 1'b0;
			pend_op_q   <= SEI_OP_NONE;
			pend_addr_q <= '0;
			pend_data_q <= '0;
		end else if (i_chip_select) begin
			if (lk_state_q == SEI_LK_IDLE && i_serial_in) begin
				armed_q  <= 1'b0;
				sb_tgl_q <= ~sb_tgl_q;
			end
			if (lk_state_q == SEI_LK_CMD && bit_cnt_q == CMD_LAST_BIT) begin
				pend_op_q   <= cmd_op;
				pend_addr_q <= cmd_word[AW-1:0];
				case (cmd_op)
					SEI_OP_ENABLE:  enable_q <= 1'b1;
					SEI_OP_DISABLE: enable_q <= 1'b0;
					SEI_OP_ERASE, SEI_OP_ER_ALL: begin
						armed_q   <= 1'b1;
						req_tgl_q <= ~req_tgl_q;
					end
					default: armed_q <= 1'b0;
				endcase
			end
			if (lk_state_q == SEI_LK_DATA && bit_cnt_q == DATA_LAST_BIT) begin
				pend_data_q <= data_in_word;
				armed_q     <= 1'b1;
				req_tgl_q   <= ~req_tgl_q;
			end
			// a clock rise after the last bit voids the programming request
			if (lk_state_q == SEI_LK_DONE) begin
				armed_q <= 1'b0;
			end
		end
	end

	// ---------------- system domain ----------------
	logic              cs_s;
	logic              armed_s;
	logic              req_s;
	logic              sb_s;
	logic              enable_s;
	logic              req_seen_q;
	logic              sb_seen_q;
	logic              cs_prev_q;
	logic              busy_q;
	logic [PROG_W-1:0] prog_cnt_q;
	logic              status_mode_q;
	logic              prog_last;


	// pending op, address and data stay unsynchronised: they settle long
	// before the request toggle is seen through its two flip-flops
	sei_sync2 #(.W(5)) u_to_sys (
		.i_clk   (i_clk_sys),
		.i_async ({i_chip_select, armed_q, req_tgl_q, sb_tgl_q, enable_q}),
		.o_sync  ({cs_s, armed_s, req_s, sb_s, enable_s})
	);


	// last cycle of the self-timed programming run
	assign prog_last = busy_q && (prog_cnt_q == PROG_W'(1));

	// start waits for select low, so a request seen early still
	// begins on the falling edge of select
	always_ff @(posedge i_clk_sys) begin
		if (!i_reset_n) begin
			busy_q     <= RST_BUSY;
			prog_cnt_q <= '0;
			req_seen_q <= 1'b0;
		end else if (busy_q) begin
			prog_cnt_q <= prog_cnt_q - PROG_W'(1);
			if (prog_last) begin
				busy_q <= 1'b0;
			end
		end else if (req_s != req_seen_q && !cs_s) begin
			req_seen_q <= req_s;
			if (armed_s && enable_s) begin
				busy_q     <= 1'b1;
				prog_cnt_q <= PROG_W'(PROG_CYCLES);
			end
		end
	end

	// array changes only at the end of a cycle, which keeps reads quasi-static
	always_ff @(posedge i_clk_sys) begin
		if (prog_last) begin
			case (pend_op_q)
				SEI_OP_ERASE:  mem_q[pend_addr_q] <= ERASED_WORD;
				SEI_OP_WRITE:  mem_q[pend_addr_q] <= pend_data_q;
				SEI_OP_ER_ALL: begin
					for (int i = 0; i < WORDS; i++) begin
						mem_q[i] <= ERASED_WORD;
					end
				end
				SEI_OP_WR_ALL: begin
					for (int i = 0; i < WORDS; i++) begin
						mem_q[i] <= pend_data_q;
					end
				end
				default: begin
				end
			endcase
		end
	end

	// status stays offered until a new start bit or a deselect once ready
	always_ff @(posedge i_clk_sys) begin
		if (!i_reset_n) begin
			status_mode_q <= 1'b0;
			sb_seen_q     <= 1'b0;
			cs_prev_q     <= 1'b0;
			o_status_out  <= 1'b0;
			o_status_oe   <= 1'b0;
			o_busy        <= RST_BUSY;
		end else begin
			sb_seen_q    <= sb_s;
			cs_prev_q    <= cs_s;
			o_busy       <= busy_q;
			o_status_out <= ~busy_q;
			o_status_oe  <= status_mode_q && cs_s && (sb_s == sb_seen_q);
			if (busy_q) begin
				status_mode_q <= 1'b1;
			end else if (sb_s != sb_seen_q || (cs_prev_q && !cs_s)) begin
				status_mode_q <= 1'b0;
			end
		end
	end

endmodule

// *** sei_engine_chk.sv ***
module sei_engine_chk #(
	parameter int WORDS       = 64,
	parameter int PROG_CYCLES = 20
) (
	input wire logic i_clk_sys,
	input wire logic i_reset_n,
	input wire logic i_serial_clock_pin,
	input wire logic i_chip_select,
	input wire logic o_data_out,
	input wire logic o_data_oe,
	input wire logic o_status_out,
	input wire logic o_status_oe,
	input wire logic o_busy
);
	timeunit 1ns;
	timeprecision 1ns;

	logic        neg_q;
	int unsigned bcnt_q;

	// length of the current busy run
	always_ff @(posedge i_clk_sys) begin
		if (!i_reset_n || !o_busy) begin
			bcnt_q <= 0;
		end else begin
			bcnt_q <= bcnt_q + 1;
		end
	end

	// level held after each fall; must survive up to the next rise
	always_ff @(negedge i_serial_clock_pin) begin
		neg_q <= o_data_out;
	end

	sequence oe_run;
		o_data_oe[*8];
	endsequence

	rst_idle_a: assert property (@(posedge i_clk_sys)
		!i_reset_n |=> !o_busy && !o_status_oe) else $error("outputs active after reset");
	busy_start_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		$rose(o_busy) |-> !i_chip_select && !$past(i_chip_select))
		else $error("busy began with select high");
	busy_len_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		$fell(o_busy) |-> bcnt_q + 1 >= PROG_CYCLES && bcnt_q <= PROG_CYCLES + 1)
		else $error("busy length wrong");
	no_clash_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		!(o_data_oe && o_status_oe)) else $error("both drivers enabled");
	oe_sel_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		!i_chip_select |-> !o_data_oe) else $error("read driver without select");
	busy_zero_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		o_status_oe && $past(o_status_oe) && o_busy && $past(o_busy) |-> !o_status_out)
		else $error("ready shown while busy");
	dummy_bit_a: assert property (@(posedge i_serial_clock_pin)
		disable iff (!i_chip_select || !i_reset_n) $rose(o_data_oe) |-> !o_data_out)
		else $error("dummy bit not zero");
	oe_len_a: assert property (@(posedge i_serial_clock_pin)
		disable iff (!i_chip_select || !i_reset_n)
		$rose(o_data_oe) |-> oe_run ##1 oe_run ##1 o_data_oe ##1 !o_data_oe)
		else $error("read window not 17 bits");
	out_edge_a: assert property (@(posedge i_serial_clock_pin)
		disable iff (!i_chip_select || !i_reset_n) o_data_oe |-> o_data_out == neg_q)
		else $error("read data moved off the rising edge");
endmodule

bind sei_engine sei_engine_chk #(
	.WORDS      (WORDS),
	.PROG_CYCLES(PROG_CYCLES)
) chk (
	.i_clk_sys,
	.i_reset_n,
	.i_serial_clock_pin,
	.i_chip_select,
	.o_data_out,
	.o_data_oe,
	.o_status_out,
	.o_status_oe,
	.o_busy
);

// *** sei_host.sv ***
module sei_host (
	output logic      o_sclk,
	output logic      o_cs,
	output logic      o_si,
	input  wire logic i_so
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [63:0] cap;

	// serial clock starts low; only idle clocks it outside frames
	initial begin
		o_sclk = 1'b0;
		o_cs = 1'b0;
		o_si = 1'b0;
	end

	task automatic frame(input logic [40:0] v, input int n);
		o_cs = 1'b1;
		for (int i = n - 1; i >= 0; i--) begin
			o_si = v[i];
			#15 o_sclk = 1'b1;
			#10 cap = {cap[62:0], i_so};
			#5 o_sclk = 1'b0;
		end
		o_si = 1'b0;
		#5 o_cs = 1'b0; // before any further rise
	endtask

	// clocks with select low and a start-like level, must be ignored
	task automatic idle(input int n);
		o_si = 1'b1;
		repeat (n) begin
			#15 o_sclk = 1'b1;
			#15 o_sclk = 1'b0;
		end
		o_si = 1'b0;
	endtask

	task automatic settle(output logic [1:0] st);
		o_cs = 1'b1; // status only while selected
		#500 st[1] = i_so;
		for (int k = 0; k < 400 && i_so !== 1'b1; k++) #100;
		st[0] = i_so;
		o_cs = 1'b0;
	endtask
endmodule

// *** sei_engine_tb.sv ***
module sei_engine_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import sei_pkg::*;

	logic        i_clk_sys;
	logic        i_reset_n;
	logic        i_serial_clock_pin;
	logic        i_chip_select;
	logic        i_serial_in;
	logic        o_data_out;
	logic        o_data_oe;
	logic        o_status_out;
	logic        o_status_oe;
	logic        o_busy;
	logic [15:0] mem [16];
	logic [15:0] d;
	logic [5:0]  a;
	integer      seed = 32'hCCB58B1A;
	int          err_total = 0;
	int          comparisons = 0;
	wire         serial_out = o_data_oe ? o_data_out : o_status_oe ? o_status_out : 1'bz;

	sei_engine #(
		.WORDS      (16),
		.PROG_CYCLES(20)
	) dut (
		.i_clk_sys,
		.i_reset_n,
		.i_serial_clock_pin,
		.i_chip_select,
		.i_serial_in,
		.o_data_out,
		.o_data_oe,
		.o_status_out,
		.o_status_oe,
		.o_busy
	);

	sei_host host (
		.o_sclk(i_serial_clock_pin),
		.o_cs  (i_chip_select),
		.o_si  (i_serial_in),
		.i_so  (serial_out)
	);

	initial begin
		i_clk_sys = 1'b0;
		forever #50 i_clk_sys = ~i_clk_sys;
	end

	// only the low address bits pick a word
	function automatic logic [15:0] exp_rd(logic [5:0] a);
		return mem[a[3:0]];
	endfunction

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic prog(input logic [1:0] op, input logic [5:0] a, input logic [15:0] d,
		input int n, input logic en);
		logic [1:0] st;
		@(negedge i_clk_sys);
		host.frame({16'h0, 1'b1, op, a, d} >> (25 - n), n);
		repeat (6) @(negedge i_clk_sys);
		check(16'(o_busy), 16'(en));
		if (en) begin
			host.settle(st);
			check(16'(st), 16'h1);
			if (st[0] !== 1'b1) test_done();
		end
		repeat (2) @(negedge i_clk_sys);
	endtask

	task automatic rd(input logic [5:0] a);
		@(negedge i_clk_sys);
		host.frame({16'h0, 1'b1, OPC_READ, a, 16'h0} << 2, 27);
		check(host.cap[17:2], exp_rd(a));
		check(16'(host.cap[18]), 16'h0);
		repeat (2) @(negedge i_clk_sys);
	endtask

	initial begin
		#500000;
		err_total++;
		test_done();
	end

	initial begin
		i_reset_n = 1'b0;
		fork
			host.idle(14);
			repeat (4) @(negedge i_clk_sys);
		join
		@(negedge i_clk_sys);
		i_reset_n = 1'b1;
		host.idle(4);
		prog(OPC_WRITE, 6'h05, 16'h1234, 25, 1'b0);
		prog(OPC_SPECIAL, {SUB_ENABLE, 4'h9}, 16'h0, 9, 1'b0);
		d = 16'($random(seed));
		prog(OPC_SPECIAL, {SUB_WR_ALL, 4'h3}, d, 25, 1'b1);
		foreach (mem[i]) mem[i] = d;
		repeat (4) rd(6'($random(seed)));
		$display("fill test done");
		for (int i = 0; i < 6; i++) begin
			a = 6'($random(seed));
			d = (i == 0) ? 16'h0 : 16'($random(seed));
			prog(OPC_WRITE, a, d, 25, 1'b1);
			mem[a[3:0]] = d;
			rd(a ^ 6'h10);
		end
		$display("write test done");
		prog(OPC_ERASE, a, 16'h0, 9, 1'b1);
		mem[a[3:0]] = ERASED_WORD;
		rd(a);
		prog(OPC_SPECIAL, {SUB_DISABLE, 4'hC}, 16'h0, 9, 1'b0);
		prog(OPC_WRITE, a, 16'h5A5A, 25, 1'b0);
		prog(OPC_SPECIAL, {SUB_ER_ALL, 4'h0}, 16'h0, 9, 1'b0);
		rd(a);
		$display("protect test done");
		prog(OPC_SPECIAL, {SUB_ENABLE, 4'h6}, 16'h0, 9, 1'b0);
		prog(OPC_SPECIAL, {SUB_ER_ALL, 4'hF}, 16'h0, 9, 1'b1);
		foreach (mem[i]) mem[i] = ERASED_WORD;
		repeat (3) rd(6'($random(seed)));
		$display("erase all test done");
		test_done();
	end
endmodule
